// file: iee_link_if.sv
`timescale 1ns/10ps
interface iee_link_if;
    logic scl;
    logic m_sda_o;
    logic m_sda_oe;
    logic s_sda_o;
    logic s_sda_oe;
    logic sda;

    // Pull-up: line is low only where someone drives a zero
    assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

    modport master (
        output scl,
        output m_sda_o,
        output m_sda_oe,
        input  sda
    );

    modport slave (
        input  scl,
        input  sda,
        output s_sda_o,
        output s_sda_oe
    );
endinterface : iee_link_if

// file: iee_link_props.sv
`timescale 1ns/10ps
module iee_link_props (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic scl,
    input wire logic m_sda_o,
    input wire logic m_sda_oe,
    input wire logic s_sda_o,
    input wire logic s_sda_oe,
    input wire logic sda
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    sequence start_c;
        scl && $past(scl) && $fell(sda);
    endsequence
    sequence stop_c;
        scl && $past(scl) && $rose(sda);
    endsequence

    a_slave_open_drain: assert property (s_sda_oe |-> !s_sda_o)
        else $error("slave data output not open drain");
    a_master_open_drain: assert property (m_sda_oe |-> !m_sda_o)
        else $error("master data output not open drain");
    a_slave_moves_low: assert property ($changed(s_sda_oe) |-> !scl)
        else $error("slave data changed while clock high");
    a_slave_after_fall: assert property ($rose(s_sda_oe) |-> !$past(scl, 2))
        else $error("slave drove data too soon after clock fall");
    a_slave_hold_high: assert property ($rose(scl) |=> $stable(s_sda_oe) [*8])
        else $error("slave data not stable over clock high");
    a_scl_high_width: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high period too short");
    a_idle_at_start: assert property (start_c |-> !s_sda_oe)
        else $error("slave driving at start");
    a_idle_at_stop: assert property (stop_c |-> !s_sda_oe [*5])
        else $error("slave driving after stop");
endmodule : iee_link_props

// file: iee_master.sv
`timescale 1ns/10ps
module iee_master #(
    parameter int QTR   = iee_pkg::QTR_CYC,
    parameter int LEN_W = 8
) (
    input  wire logic               mclk,
    input  wire logic               resetn,
    iee_link_if.master              lnk,
    input  wire logic               cmd_valid,
    output logic                    cmd_ready,
    input  wire logic               cmd_rd,
    input  wire logic               cmd_wa,
    input  wire logic [2:0]         cmd_sel,
    input  wire logic [15:0]        cmd_addr,
    input  wire logic [LEN_W-1:0]   cmd_len,
    input  wire logic [7:0]         tx_data,
    output logic                    tx_take,
    output logic [7:0]              rx_data,
    output logic                    rx_valid,
    output logic                    done,
    output logic                    nack
);
    import iee_pkg::*;

    localparam int DW = $clog2(QTR);
    localparam logic [DW-1:0]    QTR_LAST = DW'(QTR - 1);
    localparam logic [LEN_W-1:0] ONE      = LEN_W'(1);

    // Slave needs sync plus edge detect before the sample quarter
    if (QTR < 8) begin : g_chk
        $error("QTR too short for the slave's synchroniser");
    end

    iee_mst_t           st_ff;
    iee_ph_t            ph_ff;
    logic [DW-1:0]      div_ff;
    logic [1:0]         q_ff;
    logic [3:0]         bit_ff;
    logic [8:0]         out_ff;
    logic [8:0]         in_ff;
    logic [LEN_W-1:0]   rem_ff;
    logic               rd_ff;
    logic [2:0]         sel_ff;
    logic [15:0]        addr_ff;
    logic               scl_ff;
    logic               oe_ff;
    logic               s1_ff;
    logic               s2_ff;

    wire                tick     = (div_ff == QTR_LAST);
    wire                last     = (rem_ff <= ONE);
    wire                acked    = ~in_ff[0];
    wire                byte_end = (st_ff == M_BIT) && tick
                                   && (q_ff == 2'd3) && (bit_ff == BYTE_BITS);

    assign lnk.scl      = scl_ff;
    assign lnk.m_sda_o  = 1'b0;
    assign lnk.m_sda_oe = oe_ff;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s1_ff <= 1'b1;
            s2_ff <= 1'b1;
        end else begin
            s1_ff <= lnk.sda;
            s2_ff <= s1_ff;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_ff     <= M_IDLE;
            ph_ff     <= P_ADDRW;
            div_ff    <= '0;
            q_ff      <= 2'd0;
            bit_ff    <= 4'h0;
            out_ff    <= '1;
            in_ff     <= '0;
            rem_ff    <= '0;
            rd_ff     <= 1'b0;
            sel_ff    <= 3'h0;
            addr_ff   <= 16'h0000;
            scl_ff    <= 1'b1;
            oe_ff     <= 1'b0;
            cmd_ready <= 1'b1;
            tx_take   <= 1'b0;
            rx_data   <= 8'h00;
            rx_valid  <= 1'b0;
            done      <= 1'b0;
            nack      <= 1'b0;
        end else begin
            tx_take  <= 1'b0;
            rx_valid <= 1'b0;
            done     <= 1'b0;
            div_ff   <= tick ? '0 : div_ff + {{(DW-1){1'b0}}, 1'b1};
            if (tick) begin
                q_ff <= q_ff + 2'd1;
            end
            case (st_ff)
                M_IDLE: begin
                    div_ff <= '0;
                    q_ff   <= 2'd0;
                    if (cmd_valid && cmd_ready) begin
                        cmd_ready <= 1'b0;
                        nack      <= 1'b0;
                        rd_ff     <= cmd_rd;
                        sel_ff    <= cmd_sel;
                        addr_ff   <= cmd_addr;
                        rem_ff    <= cmd_len;
                        ph_ff     <= (cmd_rd && !cmd_wa) ? P_ADDRR : P_ADDRW;
                        st_ff     <= M_START; // RL4
                    end
                end
                M_START: if (tick) begin
                    case (q_ff)
                        2'd0: begin
                            scl_ff <= 1'b0;
                            oe_ff  <= 1'b0;
                        end
                        2'd1: scl_ff <= 1'b1;
                        2'd2: oe_ff <= 1'b1; // RL5
                        default: begin
                            scl_ff <= 1'b0;
                            bit_ff <= 4'h0;
                            out_ff <= {DEV_TYPE, sel_ff,
                                       ph_ff == P_ADDRR, 1'b1}; // RL8
                            st_ff  <= M_BIT;
                        end
                    endcase
                end
                M_BIT: if (tick) begin
                    case (q_ff)
                        2'd0: oe_ff <= ~out_ff[8];
                        2'd1: scl_ff <= 1'b1;
                        2'd2: in_ff <= {in_ff[7:0], s2_ff};
                        default: begin
                            scl_ff <= 1'b0;
                            out_ff <= {out_ff[7:0], 1'b1};
                            bit_ff <= bit_ff + 4'h1;
                        end
                    endcase
                end
                M_STOP: if (tick) begin
                    case (q_ff)
                        2'd0: begin
                            scl_ff <= 1'b0;
                            oe_ff  <= 1'b1;
                        end
                        2'd1: scl_ff <= 1'b1;
                        2'd2: oe_ff <= 1'b0;
                        default: begin
                            st_ff     <= M_IDLE;
                            done      <= 1'b1;
                            cmd_ready <= 1'b1;
                        end
                    endcase
                end
                default: st_ff <= M_IDLE;
            endcase
            if (byte_end) begin
                bit_ff <= 4'h0;
                if ((ph_ff == P_DATA) && rd_ff) begin
                    rx_data  <= in_ff[8:1];
                    rx_valid <= 1'b1;
                    rem_ff   <= rem_ff - ONE;
                    out_ff   <= {8'hFF, rem_ff <= LEN_W'(2)}; // RL10
                    if (last) begin
                        st_ff <= M_STOP;
                    end
                end else if (!acked) begin
                    nack  <= 1'b1;
                    st_ff <= M_STOP;
                end else begin
                    case (ph_ff)
                        P_ADDRW: begin
                            ph_ff  <= P_AHI;
                            out_ff <= {addr_ff[15:8], 1'b1};
                        end
                        P_AHI: begin
                            ph_ff  <= P_ALO;
                            out_ff <= {addr_ff[7:0], 1'b1};
                        end
                        P_ALO: begin
                            if (rd_ff) begin
                                ph_ff <= P_ADDRR; // RL20
                                st_ff <= M_START;
                            end else begin
                                ph_ff   <= P_DATA;
                                out_ff  <= {tx_data, 1'b1};
                                tx_take <= 1'b1;
                            end
                        end
                        P_ADDRR: begin
                            ph_ff  <= P_DATA;
                            out_ff <= {8'hFF, last};
                        end
                        default: begin
                            rem_ff <= rem_ff - ONE;
                            if (last) begin
                                st_ff <= M_STOP; // RL11
                            end else begin
                                out_ff  <= {tx_data, 1'b1};
                                tx_take <= 1'b1;
                            end
                        end
                    endcase
                end
            end
        end
    end
endmodule : iee_master

// file: iee_pkg.sv
package iee_pkg;
    localparam int MCLK_KHZ     = 40000;
    localparam int SCL_KHZ      = 100;
    localparam int QTR_CYC      = MCLK_KHZ / (4 * SCL_KHZ);
    localparam int WR_TIME_MS   = 5;
    localparam int WR_CYC       = WR_TIME_MS * MCLK_KHZ;
    localparam int MEM_AW       = 15;
    localparam int PAGE_BW      = 6;
    localparam int PAGE_SIZE    = 64;
    localparam int SYNC_W       = 6;
    // Arbitrary type code, not a real product value
    localparam logic [3:0] DEV_TYPE   = 4'h5;
    localparam logic [7:0] ERASED     = 8'hFF;
    localparam logic [3:0] BYTE_BITS  = 4'h8;

    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_RX   = 5'b00010,
        S_ACK  = 5'b00100,
        S_TX   = 5'b01000,
        S_MACK = 5'b10000
    } iee_sst_t;

    typedef enum logic [3:0] {
        K_SLV  = 4'b0001,
        K_AHI  = 4'b0010,
        K_ALO  = 4'b0100,
        K_DATA = 4'b1000
    } iee_kind_t;

    typedef enum logic [3:0] {
        M_IDLE  = 4'b0001,
        M_START = 4'b0010,
        M_BIT   = 4'b0100,
        M_STOP  = 4'b1000
    } iee_mst_t;

    typedef enum logic [4:0] {
        P_ADDRW = 5'b00001,
        P_AHI   = 5'b00010,
        P_ALO   = 5'b00100,
        P_ADDRR = 5'b01000,
        P_DATA  = 5'b10000
    } iee_ph_t;
endpackage : iee_pkg

// file: iee_slave.sv
// How it works
// [RL1] Reset abandons everything, returns to standby
// [RL2] Sample on SCL rise, change after fall
// [RL3] Data line open drain, zero pulls low
// [RL4] Master starts only on idle bus
// [RL5] SDA edges while SCL high: START/STOP
// [RL6] Ignore traffic until a START
// [RL7] STOP after write programs; after read idles
// [RL8] Address: type, three straps, direction bit
// [RL9] Acknowledge address, word address, data bytes
// [RL10] Read: send byte, release, continue on ack
// [RL11] Byte write: address, two words, data, STOP
// [RL12] Word address: skip top, page, in-page byte
// [RL13] Page counter wraps within 64 bytes
// [RL14] Busy programming: never acknowledge address
// [RL15] Write protect strobed before first data byte
// [RL16] Protect high blocks all writes
// [RL17] Array starts all FF
// [RL18] Counter points after last byte accessed
// [RL19] Read address: ack, send byte at counter
// [RL20] Dummy write loads counter, no write
// [RL21] Sequential read wraps end to start
// [RL22] Programming time is a cycle parameter
// [RL23] Pins synchronised and edge-detected first
`timescale 1ns/10ps
module iee_slave #(
    parameter int WR_CYCLES = iee_pkg::WR_CYC
) (
    input  wire logic   mclk,
    input  wire logic   resetn,
    iee_link_if.slave   lnk,
    input  wire logic   strap_sel_bit_lo,
    input  wire logic   strap_sel_bit_mid,
    input  wire logic   strap_sel_bit_hi,
    input  wire logic   write_prot,
    output logic        wr_busy
);
    import iee_pkg::*;

    localparam int CW = $clog2(WR_CYCLES + 1);
    localparam logic [CW-1:0] BUSY_LAST = CW'(WR_CYCLES - 1);
    localparam logic [CW-1:0] PAGE_END  = CW'(PAGE_SIZE);

    if (WR_CYCLES < PAGE_SIZE) begin : g_chk
        $error("WR_CYCLES must cover one page commit");
    end

    logic [SYNC_W-1:0]  sy1_ff;
    logic [SYNC_W-1:0]  sy2_ff;
    logic               scl_d_ff;
    logic               sda_d_ff;
    iee_sst_t           st_ff;
    iee_kind_t          kind_ff;
    logic [3:0]         bit_ff;
    logic [7:0]         sh_ff;
    logic               rd_ff;
    logic [7:0]         ahi_ff;
    logic [MEM_AW-1:0]  cnt_ff;
    logic               wpl_ff;
    logic               wpend_ff;
    logic               mack_ff;
    logic               oe_ff;
    logic               busy_ff;
    logic [CW-1:0]      bcnt_ff;
    logic [PAGE_SIZE-1:0] pvld_ff;
    // Delivery state; no reset, contents survive power loss
    logic [7:0]         mem  [0:(2**MEM_AW)-1] = '{default: ERASED}; // RL17
    logic [7:0]         pbuf [0:PAGE_SIZE-1];

    wire                scl_s     = sy2_ff[0];
    wire                sda_s     = sy2_ff[1];
    wire  [2:0]         straps    = sy2_ff[4:2];
    wire                wp_s      = sy2_ff[5];
    wire                scl_rise  = scl_s & ~scl_d_ff;
    wire                scl_fall  = ~scl_s & scl_d_ff;
    wire                bus_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    wire                bus_stop  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
    wire                byte_done = (st_ff == S_RX) && scl_fall
                                    && (bit_ff == BYTE_BITS);
    wire                addr_hit  = (sh_ff[7:4] == DEV_TYPE)
                                    && (sh_ff[3:1] == straps) && !busy_ff;
    wire                ack_now   = (kind_ff == K_SLV)  ? addr_hit :
                                    (kind_ff == K_DATA) ? !wpl_ff : 1'b1;
    wire                buf_we    = byte_done && (kind_ff == K_DATA)
                                    && !wpl_ff;
    wire  [7:0]         tx_byte   = mem[cnt_ff];
    wire  [PAGE_BW-1:0] pg_off    = cnt_ff[PAGE_BW-1:0];
    wire  [PAGE_BW-1:0] cm_off    = bcnt_ff[PAGE_BW-1:0];
    wire                commit    = busy_ff && (bcnt_ff < PAGE_END)
                                    && pvld_ff[cm_off];
    wire                busy_end  = busy_ff && (bcnt_ff == BUSY_LAST);

    assign lnk.s_sda_o  = 1'b0; // RL3
    assign lnk.s_sda_oe = oe_ff; // RL3
    assign wr_busy      = busy_ff;

    // Pins come from the far side of the clock boundary
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sy1_ff   <= '1;
            sy2_ff   <= '1;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            sy1_ff   <= {write_prot, strap_sel_bit_hi, strap_sel_bit_mid,
                         strap_sel_bit_lo, lnk.sda, lnk.scl}; // RL23
            sy2_ff   <= sy1_ff; // RL23
            scl_d_ff <= sy2_ff[0]; // RL23
            sda_d_ff <= sy2_ff[1]; // RL23
        end
    end

    // One page byte per cycle at the start of the write time
    always_ff @(posedge mclk) begin
        if (commit) begin
            mem[{cnt_ff[MEM_AW-1:PAGE_BW], cm_off}] <= pbuf[cm_off]; // RL22
        end
        if (buf_we) begin
            pbuf[pg_off] <= sh_ff; // RL13
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_ff    <= S_IDLE; // RL1
            kind_ff  <= K_SLV;
            bit_ff   <= 4'h0;
            sh_ff    <= 8'h00;
            rd_ff    <= 1'b0;
            ahi_ff   <= 8'h00;
            cnt_ff   <= '0;
            wpl_ff   <= 1'b0;
            wpend_ff <= 1'b0;
            mack_ff  <= 1'b0;
            oe_ff    <= 1'b0;
            busy_ff  <= 1'b0; // RL1
            bcnt_ff  <= '0;
            pvld_ff  <= '0;
        end else begin
            if (bus_start) begin
                st_ff    <= S_RX; // RL5 RL6
                kind_ff  <= K_SLV;
                bit_ff   <= 4'h0;
                oe_ff    <= 1'b0;
                wpend_ff <= 1'b0; // RL20
                wpl_ff   <= 1'b0;
                if (!busy_ff) begin
                    pvld_ff <= '0;
                end
            end else if (bus_stop) begin
                st_ff    <= S_IDLE; // RL7
                oe_ff    <= 1'b0;
                wpend_ff <= 1'b0;
                if (wpend_ff) begin
                    busy_ff <= 1'b1; // RL7
                    bcnt_ff <= '0;
                end
            end else begin
                case (st_ff)
                    S_IDLE: begin
                        oe_ff <= 1'b0; // RL6
                    end
                    S_RX: begin
                        if (scl_rise) begin
                            sh_ff  <= {sh_ff[6:0], sda_s}; // RL2
                            bit_ff <= bit_ff + 4'h1;
                        end else if (byte_done && ack_now) begin
                            oe_ff <= 1'b1; // RL9
                            st_ff <= S_ACK;
                            case (kind_ff)
                                K_SLV: begin
                                    rd_ff   <= sh_ff[0]; // RL8
                                    kind_ff <= K_AHI;
                                end
                                K_AHI: begin
                                    ahi_ff  <= sh_ff;
                                    kind_ff <= K_ALO;
                                end
                                K_ALO: begin
                                    cnt_ff  <= {ahi_ff[6:0], sh_ff}; // RL12
                                    kind_ff <= K_DATA;
                                end
                                default: begin
                                    cnt_ff[PAGE_BW-1:0] <= pg_off + 6'h01; // RL13
                                    wpend_ff <= 1'b1; // RL11
                                    pvld_ff[pg_off] <= 1'b1;
                                end
                            endcase
                        end else if (byte_done) begin
                            st_ff <= S_IDLE; // RL14
                        end
                    end
                    S_ACK: begin
                        if (scl_fall && rd_ff) begin
                            sh_ff  <= tx_byte; // RL19
                            cnt_ff <= cnt_ff + 15'h0001; // RL18
                            oe_ff  <= ~tx_byte[7]; // RL2
                            bit_ff <= 4'h0;
                            st_ff  <= S_TX;
                        end else if (scl_fall) begin
                            oe_ff  <= 1'b0;
                            bit_ff <= 4'h0;
                            st_ff  <= S_RX;
                            if ((kind_ff == K_DATA) && !wpend_ff) begin
                                wpl_ff <= wp_s; // RL15 RL16
                            end
                        end
                    end
                    S_TX: begin
                        if (scl_rise) begin
                            bit_ff <= bit_ff + 4'h1;
                        end else if (scl_fall && (bit_ff == BYTE_BITS)) begin
                            oe_ff <= 1'b0; // RL10
                            st_ff <= S_MACK;
                        end else if (scl_fall) begin
                            sh_ff <= {sh_ff[6:0], 1'b0};
                            oe_ff <= ~sh_ff[6]; // RL2
                        end
                    end
                    S_MACK: begin
                        if (scl_rise) begin
                            mack_ff <= ~sda_s; // RL10
                        end else if (scl_fall && mack_ff) begin
                            sh_ff  <= tx_byte; // RL21
                            cnt_ff <= cnt_ff + 15'h0001; // RL21
                            oe_ff  <= ~tx_byte[7];
                            bit_ff <= 4'h0;
                            st_ff  <= S_TX;
                        end else if (scl_fall) begin
                            st_ff <= S_IDLE; // RL10
                        end
                    end
                    default: begin
                        st_ff <= S_IDLE;
                    end
                endcase
            end
            // Busy runs beside the bus logic; address gets no ack meanwhile
            if (busy_ff) begin
                bcnt_ff <= bcnt_ff + {{(CW-1){1'b0}}, 1'b1}; // RL22
            end
            if (busy_end) begin
                busy_ff <= 1'b0; // RL22
                pvld_ff <= '0;
            end
        end
    end
endmodule : iee_slave

// file: iee_slave_test.sv
`timescale 1ns/10ps
module iee_slave_test;
    import iee_pkg::*;
    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic        cmd_valid = 1'b0;
    logic        cmd_rd = 1'b0;
    logic        cmd_wa = 1'b0;
    logic        write_prot = 1'b0;
    logic [2:0]  cmd_sel = 3'h0;
    logic [2:0]  straps = 3'h0;
    logic [15:0] cmd_addr = 16'h0;
    logic [7:0]  cmd_len = 8'h0;
    logic [7:0]  tx_data = 8'h0;
    logic [14:0] ctr = 15'h0;
    wire  [7:0]  rx_data;
    wire         cmd_ready, tx_take, rx_valid, done, nack, wr_busy;
    logic [7:0]  exp_rx [$];
    logic        exp_nk [$];
    logic [7:0]  wq [$];
    logic [7:0]  mdl [logic [14:0]];
    int          miscompares = 0;
    int          check_count = 0;

    always #12.5 mclk = ~mclk;

    iee_link_if lnk ();
    // Short quarter and write time keep the run small
    iee_master #(.QTR(8)) iee_master_inst (.mclk(mclk), .resetn(resetn),
        .lnk(lnk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_rd(cmd_rd), .cmd_wa(cmd_wa), .cmd_sel(cmd_sel),
        .cmd_addr(cmd_addr), .cmd_len(cmd_len), .tx_data(tx_data),
        .tx_take(tx_take), .rx_data(rx_data), .rx_valid(rx_valid),
        .done(done), .nack(nack));
    iee_slave #(.WR_CYCLES(2000)) iee_slave_inst (.mclk(mclk),
        .resetn(resetn), .lnk(lnk), .strap_sel_bit_lo(straps[0]),
        .strap_sel_bit_mid(straps[1]), .strap_sel_bit_hi(straps[2]),
        .write_prot(write_prot), .wr_busy(wr_busy));
    iee_link_props iee_link_props_inst (.mclk(mclk), .resetn(resetn),
        .scl(lnk.scl), .m_sda_o(lnk.m_sda_o), .m_sda_oe(lnk.m_sda_oe),
        .s_sda_o(lnk.s_sda_o), .s_sda_oe(lnk.s_sda_oe), .sda(lnk.sda));

    task automatic chk8(string what, logic [7:0] e, logic [7:0] s);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask : chk8

    task automatic chk1(string what, logic e, logic s);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR %s expected %b seen %b", what, e, s);
        end
    endtask : chk1

    task automatic test_done;
        if (miscompares == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    // Pop later than the edge so the master samples the current byte
    always @(posedge mclk) begin
        if (tx_take === 1'b1) begin
            #2 void'(wq.pop_front());
            tx_data = wq.size() ? wq[0] : 8'h00;
        end
    end

    always @(posedge mclk) begin
        if (rx_valid === 1'b1)
            chk8("rx_data", exp_rx.size() ? exp_rx.pop_front() : 'x, rx_data);
        if (done === 1'b1)
            chk1("nack", exp_nk.size() ? exp_nk.pop_front() : 'x, nack);
    end

    task automatic run(bit rd, bit wa, logic [15:0] a, int n, bit nk);
        int k;
        logic [7:0] b;
        k = 0;
        wq.delete();
        exp_nk.push_back(nk);
        if (!nk && wa)
            ctr = a[14:0];
        for (int i = 0; i < n; i++) begin
            b = 8'($urandom);
            wq.push_back(b);
            if (!nk && rd)
                exp_rx.push_back(mdl.exists(ctr + 15'(i)) ? mdl[ctr + 15'(i)] : ERASED);
            if (!nk && !rd)
                mdl[{ctr[14:6], 6'(ctr[5:0] + i)}] = b;
        end
        if (!nk)
            ctr = rd ? ctr + 15'(n) : {ctr[14:6], 6'(ctr[5:0] + n)};
        @(posedge mclk);
        #2;
        tx_data = wq[0];
        {cmd_rd, cmd_wa, cmd_addr, cmd_len} = {rd, wa, a, 8'(n)};
        cmd_valid = 1'b1;
        do @(posedge mclk); while (cmd_ready !== 1'b1);
        #2 cmd_valid = 1'b0;
        while (done !== 1'b1 && k < 9000) begin
            @(posedge mclk);
            k++;
        end
        if (k == 9000)
            miscompares++;
    endtask : run

    initial begin
        void'($urandom(13355));
        straps = 3'($urandom);
        cmd_sel = straps;
        repeat (16) @(posedge mclk);
        #2 resetn = 1'b1;
        run(1, 1, {1'b0, 15'($urandom)}, 2, 0);
        run(0, 1, 16'h803E, 4, 0);
        chk1("wr_busy", 1'b1, wr_busy);
        run(1, 0, 16'h0000, 1, 1);
        while (wr_busy === 1'b1) @(posedge mclk);
        run(1, 1, 16'h7FFF, 3, 0);
        chk1("wr_busy", 1'b0, wr_busy);
        run(1, 0, 16'h0000, 1, 0);
        run(1, 1, 16'h003E, 2, 0);
        #2 write_prot = 1'b1;
        run(0, 1, 16'h0000, 1, 1);
        chk1("wr_busy", 1'b0, wr_busy);
        #2 write_prot = 1'b0;
        run(1, 1, 16'h0000, 1, 0);
        #2 cmd_sel = straps ^ 3'h5;
        run(1, 0, 16'h0000, 1, 1);
        test_done();
    end

    initial begin
        #1000000;
        miscompares++;
        test_done();
    end
endmodule : iee_slave_test
